// [verilog/usb_device_command_port.sv]
// Purpose: Command interpreter behind the 16-bit processor port of the device controller
// Assumes: Bus pins are asynchronous and held long enough to pass the synchroniser
// Notes:   Endpoint memory and USB signalling live in the endpoint engine outside
`timescale 1ns/10ps
`include "usb_cmd_port_cfg.svh"

// Operation
// - A write with address_bit_zero high takes data bits 7..0 as command code.
// - Commands without data phase execute immediately when the code arrives.
// - Accesses with address_bit_zero low move data for the current command.
// - Wide registers go over successive data accesses, least significant word first.
// - Upper byte ignored in command phase; undefined bytes ignored in data phase.
// - Odd-length IN packet: upper byte of last word is not sent.
// - First buffer word carries the packet byte count ahead of payload.
// - Codes 20..2F write endpoint setup, 30..3F read it back.
// - Codes 01..0F load IN buffers; 64 bytes, or 1023 when isochronous.
// - Codes 10, 12..1F read OUT buffers, same size limits; 11 is refused.
// - Codes 40..4F stall an endpoint, no data phase.
// - Codes 80..8F remove the stall, no data phase.
// - Codes 50..5F return one word of endpoint state.
// - Codes D0..DF return one word from the endpoint state copy.
// - Codes 61..6F validate an IN buffer; 60 is refused.
// - Codes 70, 72..7F clear an OUT buffer; 71 is refused.
// - Reading the state copy changes no state or interrupt flag.
// - A buffer of N bytes takes the count word plus (N+1)/2 data accesses.
module usb_device_command_port
  import usb_cmd_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         bus_cs_n,
  input  wire logic         bus_wr_n,
  input  wire logic         bus_rd_n,
  input  wire logic         address_bit_zero,
  input  wire logic [15:0]  bus_data_in,
  output logic      [15:0]  bus_data_out,
  output logic              bus_data_oe_n,
  output logic              bus_wait,
  input  wire logic [127:0] ep_state_in,
  input  wire logic [15:0]  ep_rd_data,
  output logic              ep_rd_pop,
  output logic              state_read_ack,
  output logic              validate_pulse,
  output logic              clear_pulse,
  output logic      [3:0]   target_ep,
  output logic              ep_wr_valid,
  input  wire logic         ep_wr_ready,
  output logic      [15:0]  ep_wr_data,
  output logic      [3:0]   ep_wr_ep,
  output logic              ep_wr_first,
  output logic              ep_wr_last,
  output logic              ep_wr_upper_valid,
  output logic      [15:0]  stall_flags,
  output logic      [127:0] endpoint_setup_out,
  output logic      [7:0]   device_address_out,
  output logic      [7:0]   operating_mode_out,
  output logic      [15:0]  hardware_setup_out,
  output logic      [31:0]  irq_enable_out,
  output logic      [15:0]  dma_setup_out,
  output logic      [15:0]  dma_byte_count_out
);

  logic [19:0]  sync_a;
  logic [19:0]  sync_b;
  logic [15:0]  s_data;
  logic         s_a0;
  logic         wr_act;
  logic         rd_act;
  logic         wr_prev;
  logic         rd_prev;
  logic         write_start;
  logic         read_start;
  logic         cmd_take;
  logic         data_wr;
  logic         data_rd;
  cmd_class_t   new_class;
  cmd_class_t   cur_class;
  logic [7:0]   cur_code;
  logic [3:0]   cur_ep;
  logic         word_idx;
  logic         soft_reset;
  phase_t       phase;
  logic [9:0]   words_left;
  logic         byte_odd;
  logic [9:0]   count_src;
  logic [9:0]   buf_limit;
  logic [9:0]   clamped;
  logic [9:0]   next_words;
  logic         buf_access;
  logic         push_valid;
  logic         push_last;
  logic         push_upper;
  logic         fifo_in_ready;
  logic [22:0]  fifo_out;
  logic [15:0]  read_word;
  logic [7:0]   endpoint_setup_reg [16];
  logic [7:0]   ep_state_word [16];
  logic [7:0]   device_address_reg;
  logic [7:0]   operating_mode_reg;
  logic [15:0]  hardware_setup_reg;
  logic [31:0]  irq_enable_reg;
  logic [15:0]  dma_setup_reg;
  logic [15:0]  dma_byte_count_reg;

  // Two-stage synchroniser for every bus pin; strobes idle high at reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_a <= 20'hE_0000;
      sync_b <= 20'hE_0000;
    end else begin
      sync_a <= {bus_cs_n, bus_wr_n, bus_rd_n, address_bit_zero, bus_data_in};
      sync_b <= sync_a;
    end
  end

  assign s_data = sync_b[15:0];
  assign s_a0   = sync_b[16];
  assign wr_act = ~sync_b[19] & ~sync_b[18];
  assign rd_act = ~sync_b[19] & ~sync_b[17];

  // Edge detection on the synchronised strobes; one event per access
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
    end else begin
      wr_prev <= wr_act;
      rd_prev <= rd_act;
    end
  end

  assign write_start = wr_act & ~wr_prev;
  assign read_start  = rd_act & ~rd_prev;
  assign cmd_take    = write_start & s_a0;
  assign data_wr     = write_start & ~s_a0;
  assign data_rd     = read_start & ~s_a0;
  assign new_class   = cmd_class(s_data[7:0]);
  assign soft_reset  = cmd_take && (new_class == CMD_RESET);
  assign cur_ep      = cur_code[3:0];

  // Command latch; upper data byte never reaches the decoder
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_code  <= 8'h00;
      cur_class <= CMD_NONE;
      word_idx  <= 1'b0;
    end else if (cmd_take) begin
      cur_code  <= s_data[7:0];
      cur_class <= new_class;
      word_idx  <= 1'b0;
    end else if (data_wr || data_rd) begin
      word_idx  <= 1'b1;
    end
  end

  // Buffer length bookkeeping; count word comes first
  assign count_src  = (cur_class == CMD_BUF_RD) ? ep_rd_data[9:0] : s_data[9:0];
  assign buf_limit  = byte_limit(endpoint_setup_reg[cur_ep][`SETUP_ISO_BIT]);
  assign clamped    = (count_src > buf_limit) ? buf_limit : count_src;
  assign next_words = 10'((11'(clamped) + 11'h001) >> 1);
  assign buf_access = ((cur_class == CMD_BUF_WR) && data_wr && fifo_in_ready) ||
                      ((cur_class == CMD_BUF_RD) && data_rd);

  // Transfer phase per buffer command
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase      <= PH_IDLE;
      words_left <= 10'h000;
      byte_odd   <= 1'b0;
    end else if (cmd_take) begin
      phase      <= (new_class == CMD_BUF_WR || new_class == CMD_BUF_RD) ? PH_COUNT : PH_IDLE;
      words_left <= 10'h000;
    end else if (buf_access) begin
      unique case (phase)
        PH_IDLE: begin
          phase <= PH_IDLE;                               // Extra accesses past the packet are dropped
        end
        PH_COUNT: begin
          words_left <= next_words;
          byte_odd   <= clamped[0];
          phase      <= (next_words == 10'h000) ? PH_IDLE : PH_DATA;
        end
        PH_DATA: begin
          words_left <= words_left - 10'h001;
          if (words_left == 10'h001) begin
            phase <= PH_IDLE;
          end
        end
        default: phase <= PH_IDLE;
      endcase
    end
  end

  // Entries headed for the endpoint engine
  assign push_valid = (cur_class == CMD_BUF_WR) && data_wr && (phase != PH_IDLE);
  assign push_last  = ((phase == PH_COUNT) && (next_words == 10'h000)) ||
                      ((phase == PH_DATA) && (words_left == 10'h001));
  assign push_upper = ~((phase == PH_DATA) && (words_left == 10'h001) && byte_odd);
  // Processor cannot be stalled mid-cycle, so back-pressure shows as a wait level
  assign bus_wait   = ~fifo_in_ready && (cur_class == CMD_BUF_WR);

  cmd_word_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({cur_ep, phase == PH_COUNT, push_last, push_upper, s_data}),
    .out_valid (ep_wr_valid),
    .out_ready (ep_wr_ready),
    .out_data  (fifo_out)
  );

  assign ep_wr_ep          = fifo_out[22:19];
  assign ep_wr_first       = fifo_out[18];
  assign ep_wr_last        = fifo_out[17];
  assign ep_wr_upper_valid = fifo_out[16];
  assign ep_wr_data        = fifo_out[15:0];

  // Control registers; low word of the interrupt enable goes first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      device_address_reg <= `ADDR_RESET;
      operating_mode_reg <= `MODE_RESET;
      hardware_setup_reg <= `HWSET_RESET;
      irq_enable_reg     <= `IRQEN_RESET;
      dma_setup_reg      <= `DMASET_RESET;
      dma_byte_count_reg <= `DMACNT_RESET;
    end else if (soft_reset) begin
      device_address_reg <= `ADDR_RESET;
      operating_mode_reg <= `MODE_RESET;
      hardware_setup_reg <= `HWSET_RESET;
      irq_enable_reg     <= `IRQEN_RESET;
      dma_setup_reg      <= `DMASET_RESET;
      dma_byte_count_reg <= `DMACNT_RESET;
    end else if (data_wr && (cur_class == CMD_REG_WR)) begin
      case (cur_code)
        `CODE_ADDR_WR:   device_address_reg <= s_data[7:0];
        `CODE_MODE_WR:   operating_mode_reg <= s_data[7:0];
        `CODE_HWSET_WR:  hardware_setup_reg <= s_data;
        `CODE_IRQEN_WR: begin
          if (word_idx) begin
            irq_enable_reg[31:16] <= s_data;
          end else begin
            irq_enable_reg[15:0] <= s_data;
          end
        end
        `CODE_DMASET_WR: dma_setup_reg <= s_data;
        `CODE_DMACNT_WR: dma_byte_count_reg <= s_data;
        default:         dma_setup_reg <= dma_setup_reg;
      endcase
    end
  end

  // Endpoint setup words, one byte each
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        endpoint_setup_reg[i] <= `SETUP_RESET;
      end
    end else if (soft_reset) begin
      for (int i = 0; i < 16; i++) begin
        endpoint_setup_reg[i] <= `SETUP_RESET;
      end
    end else if (data_wr && (cur_class == CMD_SETUP_WR)) begin
      endpoint_setup_reg[cur_ep] <= s_data[7:0];
    end
  end

  // Stall flags change on the command itself, no data phase needed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stall_flags <= 16'h0000;
    end else if (soft_reset) begin
      stall_flags <= 16'h0000;
    end else if (cmd_take && (new_class == CMD_STALL)) begin
      stall_flags[s_data[3:0]] <= 1'b1;
    end else if (cmd_take && (new_class == CMD_UNSTALL)) begin
      stall_flags[s_data[3:0]] <= 1'b0;
    end
  end

  // One-cycle strobes toward the endpoint engine, plus target_ep held from the last command
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      validate_pulse <= 1'b0;
      clear_pulse    <= 1'b0;
      state_read_ack <= 1'b0;
      ep_rd_pop      <= 1'b0;
      target_ep      <= 4'h0;
    end else begin
      validate_pulse <= cmd_take && (new_class == CMD_VALIDATE);
      clear_pulse    <= cmd_take && (new_class == CMD_CLEAR);
      state_read_ack <= data_rd && (cur_class == CMD_STATE_RD);
      ep_rd_pop      <= data_rd && (cur_class == CMD_BUF_RD) && (phase != PH_IDLE);
      if (cmd_take) begin
        target_ep <= s_data[3:0];
      end
    end
  end

  // Read multiplexer; narrow registers read with a zero upper byte
  always_comb begin
    read_word = 16'h0000;
    unique case (cur_class)
      CMD_SETUP_RD: read_word = {8'h00, endpoint_setup_reg[cur_ep]};
      CMD_STATE_RD: read_word = {8'h00, ep_state_word[cur_ep]};
      CMD_COPY_RD:  read_word = {8'h00, ep_state_word[cur_ep]};
      CMD_BUF_RD:   read_word = (phase != PH_IDLE) ? ep_rd_data : 16'h0000;
      CMD_REG_RD: begin
        case (cur_code)
          `CODE_ADDR_RD:   read_word = {8'h00, device_address_reg};
          `CODE_MODE_RD:   read_word = {8'h00, operating_mode_reg};
          `CODE_HWSET_RD:  read_word = hardware_setup_reg;
          `CODE_IRQEN_RD:  read_word = word_idx ? irq_enable_reg[31:16] : irq_enable_reg[15:0];
          `CODE_DMASET_RD: read_word = dma_setup_reg;
          `CODE_DMACNT_RD: read_word = dma_byte_count_reg;
          default:         read_word = 16'h0000;
        endcase
      end
      default:      read_word = 16'h0000;
    endcase
  end

  // Read data is captured once per access and held for the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_data_out <= 16'h0000;
    end else if (data_rd) begin
      bus_data_out <= read_word;
    end
  end

  assign bus_data_oe_n = ~(rd_act & ~s_a0);

  // Flat views of the per-endpoint bytes
  for (genvar g = 0; g < 16; g++) begin : g_ep
    assign endpoint_setup_out[g*8 +: 8] = endpoint_setup_reg[g];
    assign ep_state_word[g]             = ep_state_in[g*8 +: 8];
  end

  assign device_address_out = device_address_reg;
  assign operating_mode_out = operating_mode_reg;
  assign hardware_setup_out = hardware_setup_reg;
  assign irq_enable_out     = irq_enable_reg;
  assign dma_setup_out      = dma_setup_reg;
  assign dma_byte_count_out = dma_byte_count_reg;

  // Checks on the command decode and its effects
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_cmd_code_latch: assert property (cmd_take |=> cur_code == $past(s_data[7:0]))
    else $error("command code not latched from low byte");
  a_stall_at_once: assert property ((cmd_take && s_data[7:4] == 4'h4) |=> stall_flags[target_ep])
    else $error("stall not applied on command phase");
  a_unstall_at_once: assert property ((cmd_take && s_data[7:4] == 4'h8) |=> !stall_flags[target_ep])
    else $error("stall not removed on command phase");
  a_addr_low_byte: assert property ((data_wr && cur_code == 8'hB6 && cur_class == CMD_REG_WR)
    |=> device_address_reg == $past(s_data[7:0]))
    else $error("address register did not take the low byte");
  a_setup_write: assert property ((data_wr && cur_class == CMD_SETUP_WR)
    |=> endpoint_setup_reg[$past(cur_ep)] == $past(s_data[7:0]))
    else $error("endpoint setup not written");
  a_irq_low_first: assert property ((data_wr && cur_code == 8'hC2 && !word_idx)
    |=> irq_enable_reg[15:0] == $past(s_data) ##0 word_idx)
    else $error("interrupt enable low word not first");
  a_state_read_ack: assert property ((data_rd && cur_class == CMD_STATE_RD) |=> state_read_ack)
    else $error("state read not reported");
  a_copy_read_quiet: assert property ((data_rd && cur_class == CMD_COPY_RD) |=> !state_read_ack[*2])
    else $error("state copy read disturbed flags");
  a_word_count: assert property ((buf_access && phase == PH_COUNT)
    |=> words_left == 10'(($past(11'(clamped)) + 11'h001) >> 1))
    else $error("buffer word count wrong");
  a_odd_upper_drop: assert property ((push_valid && phase == PH_DATA && words_left == 10'h001)
    |-> push_upper == !byte_odd)
    else $error("odd packet upper byte not dropped");
  a_validate_pulse: assert property ((cmd_take && s_data[7:4] == 4'h6 && s_data[3:0] != 4'h0)
    |=> validate_pulse ##1 !validate_pulse)
    else $error("validate strobe wrong");
  a_clear_refused: assert property ((cmd_take && s_data[7:0] == 8'h71) |=> !clear_pulse)
    else $error("forbidden clear code acted on");
  a_reset_cmd: assert property ((cmd_take && s_data[7:0] == 8'hF6)
    |=> stall_flags == 16'h0000 && device_address_reg == `ADDR_RESET)
    else $error("reset command did not clear registers");

  c_buf_write_end: cover property (push_valid && push_last && fifo_in_ready);
  c_buf_read_pop: cover property (ep_rd_pop);
  c_fifo_full_wait: cover property (bus_wait);
  c_irq_two_words: cover property (data_wr && cur_code == 8'hC2 && word_idx);

endmodule : usb_device_command_port

// [verilog/usb_cmd_port_cfg.svh]
// Purpose: Constants for the peripheral_side_controller command port
// Assumes: Included by the package and by the command port module
// Notes:   Command groups are decoded from the upper nibble of the code
`ifndef USB_CMD_PORT_CFG_SVH
`define USB_CMD_PORT_CFG_SVH

// Command groups (upper nibble of the command code)
`define GRP_BUF_WR      4'h0
`define GRP_BUF_RD      4'h1
`define GRP_SETUP_WR    4'h2
`define GRP_SETUP_RD    4'h3
`define GRP_STALL       4'h4
`define GRP_STATE_RD    4'h5
`define GRP_VALIDATE    4'h6
`define GRP_CLEAR       4'h7
`define GRP_UNSTALL     4'h8
`define GRP_COPY_RD     4'hD

// Register access codes, write then read
`define CODE_ADDR_WR    8'hB6
`define CODE_ADDR_RD    8'hB7
`define CODE_MODE_WR    8'hB8
`define CODE_MODE_RD    8'hB9
`define CODE_HWSET_WR   8'hBA
`define CODE_HWSET_RD   8'hBB
`define CODE_IRQEN_WR   8'hC2
`define CODE_IRQEN_RD   8'hC3
`define CODE_DMASET_WR  8'hF0
`define CODE_DMASET_RD  8'hF1
`define CODE_DMACNT_WR  8'hF2
`define CODE_DMACNT_RD  8'hF3
`define CODE_RESET      8'hF6

// Endpoint setup field positions
`define SETUP_ISO_BIT   4

// Packet size limits in bytes
`define MAX_ISO_BYTES   10'h3FF
`define MAX_BULK_BYTES  10'h040

// Reset values
`define SETUP_RESET     8'h00
`define ADDR_RESET      8'h00
`define MODE_RESET      8'h00
`define HWSET_RESET     16'h0000
`define IRQEN_RESET     32'h0000_0000
`define DMASET_RESET    16'h0000
`define DMACNT_RESET    16'h0000

// Buffering between the processor and the endpoint engine
`define FIFO_DEPTH      4
`define FIFO_WIDTH      23

`endif

// [verilog/usb_cmd_pkg.sv]
// Purpose: Types and decode helpers for the command port
// Assumes: Constants come from the cfg header
// Notes:   Illegal codes decode to cmd_none and are ignored
package usb_cmd_pkg;
`include "usb_cmd_port_cfg.svh"

  typedef enum logic [3:0] {
    CMD_NONE, CMD_BUF_WR, CMD_BUF_RD, CMD_SETUP_WR, CMD_SETUP_RD, CMD_STALL, CMD_UNSTALL,
    CMD_STATE_RD, CMD_COPY_RD, CMD_VALIDATE, CMD_CLEAR, CMD_REG_WR, CMD_REG_RD, CMD_RESET
  } cmd_class_t;

  typedef enum logic [1:0] {PH_IDLE, PH_COUNT, PH_DATA} phase_t;

  // Classify a command code; forbidden codes fall to cmd_none
  function automatic cmd_class_t cmd_class(input logic [7:0] code);
    cmd_class_t cls;
    cls = CMD_NONE;
    case (code[7:4])
      `GRP_BUF_WR:   cls = (code[3:0] == 4'h0) ? CMD_NONE : CMD_BUF_WR;
      `GRP_BUF_RD:   cls = (code[3:0] == 4'h1) ? CMD_NONE : CMD_BUF_RD;
      `GRP_SETUP_WR: cls = CMD_SETUP_WR;
      `GRP_SETUP_RD: cls = CMD_SETUP_RD;
      `GRP_STALL:    cls = CMD_STALL;
      `GRP_STATE_RD: cls = CMD_STATE_RD;
      `GRP_VALIDATE: cls = (code[3:0] == 4'h0) ? CMD_NONE : CMD_VALIDATE;
      `GRP_CLEAR:    cls = (code[3:0] == 4'h1) ? CMD_NONE : CMD_CLEAR;
      `GRP_UNSTALL:  cls = CMD_UNSTALL;
      `GRP_COPY_RD:  cls = CMD_COPY_RD;
      default: begin
        case (code)
          `CODE_ADDR_WR, `CODE_MODE_WR, `CODE_HWSET_WR, `CODE_IRQEN_WR, `CODE_DMASET_WR,
          `CODE_DMACNT_WR: cls = CMD_REG_WR;
          `CODE_ADDR_RD, `CODE_MODE_RD, `CODE_HWSET_RD, `CODE_IRQEN_RD, `CODE_DMASET_RD,
          `CODE_DMACNT_RD: cls = CMD_REG_RD;
          `CODE_RESET:     cls = CMD_RESET;
          default:         cls = CMD_NONE;
        endcase
      end
    endcase
    return cls;
  endfunction : cmd_class

  // Largest packet a buffer may hold, by endpoint kind
  function automatic logic [9:0] byte_limit(input logic iso);
    return iso ? `MAX_ISO_BYTES : `MAX_BULK_BYTES;
  endfunction : byte_limit

endpackage : usb_cmd_pkg

// [verilog/cmd_word_fifo.sv]
// Purpose: Small word FIFO between the processor port and the endpoint engine
// Assumes: Single clock, push and pop may happen in the same cycle
// Notes:   Depth must be a power of two
`timescale 1ns/10ps
module cmd_word_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  // Honest flags straight from the fill level
  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  // Storage has no reset; contents are qualified by the fill level
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : cmd_word_fifo

// [tb/cpu_bus_model.sv]
// Purpose: Processor side of the 16-bit command port
// Assumes: Pins settle 3 edges ahead of a strobe held 6 cycles
// Notes:   Released data lines show the inverse of the last word
`timescale 1ns/10ps
module cpu_bus_model (
  input  wire logic        core_clk,
  output logic             bus_cs_n,
  output logic             bus_wr_n,
  output logic             bus_rd_n,
  output logic             address_bit_zero,
  output logic [15:0]      bus_data_in,
  input  wire logic [15:0] bus_data_out,
  output logic [15:0]      rd_word,
  output logic             rd_ok
);
  initial begin
    {bus_cs_n, bus_wr_n, bus_rd_n, address_bit_zero, rd_ok} = 5'h1C;
    bus_data_in = 16'h0000;
    rd_word     = 16'h0000;
  end
  // One whole word per access, never a byte
  task automatic access(input logic cmd, input logic wr, input logic [15:0] d);
    @(posedge core_clk);
    address_bit_zero <= cmd;
    bus_data_in      <= d;
    bus_cs_n         <= 1'b0;
    repeat (3) @(posedge core_clk);
    bus_wr_n <= !wr;
    bus_rd_n <= wr;
    repeat (6) @(posedge core_clk);
    rd_word  <= bus_data_out;
    rd_ok    <= !wr;
    {bus_cs_n, bus_wr_n, bus_rd_n} <= 3'h7;
    bus_data_in <= ~d;  // No stale value after release
    @(posedge core_clk);
    rd_ok <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : access
endmodule : cpu_bus_model

// [tb/tb.sv]
// Purpose: Self-checking bench for the command port
// Assumes: Processor model drives the bus, bench plays the engine
// Notes:   Watcher pairs each read or FIFO pop with the oldest note
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import usb_cmd_pkg::*;
  logic core_clk = 0, rst = 1, ep_wr_ready = 0, drain = 0;
  logic cs_n, wr_n, rd_n, a0, oe_n, bus_wait, rd_ok, ep_wr_valid, ep_wr_first, ep_wr_last, ep_wr_upper_valid;
  logic [15:0] din, dout, rd_word, ep_wr_data, stall_flags, hw;
  logic [31:0] irq, v;
  logic [127:0] setup;
  logic [18:0] got, want, q[$];
  int checked = 0, error_cnt = 0;
  always #5 core_clk = !core_clk;
  cpu_bus_model u (.core_clk, .bus_cs_n(cs_n), .bus_wr_n(wr_n), .bus_rd_n(rd_n), .address_bit_zero(a0),
    .bus_data_in(din), .bus_data_out(dout), .rd_word, .rd_ok);
  usb_device_command_port DUT (.core_clk, .rst, .bus_cs_n(cs_n), .bus_wr_n(wr_n), .bus_rd_n(rd_n),
    .address_bit_zero(a0), .bus_data_in(din), .bus_data_out(dout), .bus_data_oe_n(oe_n), .bus_wait,
    .ep_state_in(128'h0), .ep_rd_data(16'h0000), .ep_rd_pop(), .state_read_ack(), .validate_pulse(),
    .clear_pulse(), .target_ep(), .ep_wr_valid, .ep_wr_ready, .ep_wr_data, .ep_wr_ep(), .ep_wr_first,
    .ep_wr_last, .ep_wr_upper_valid, .stall_flags, .endpoint_setup_out(setup), .device_address_out(),
    .operating_mode_out(), .hardware_setup_out(hw), .irq_enable_out(irq), .dma_setup_out(),
    .dma_byte_count_out());
  // Engine stalls at random while draining
  always @(posedge core_clk) ep_wr_ready <= drain & 1'($urandom_range(1, 0));
  // Watcher takes the oldest note for each result
  always @(posedge core_clk) if (rd_ok || (ep_wr_valid && ep_wr_ready)) begin
    got = rd_ok ? {3'h0, rd_word} : {ep_wr_first, ep_wr_last, ep_wr_upper_valid, ep_wr_data};
    if (q.size() == 0) error_cnt++;
    else begin
      want = q.pop_front();
      `CHK(got, want)
    end
  end
  task automatic conclude;
    $display("checked %0d errors %0d", checked, error_cnt);
    if (checked > 0 && error_cnt == 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    void'($urandom(78046));
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    // Junk upper byte on every stall and unstall code
    for (int e = 0; e < 16; e++) begin
      u.access(1, 1, {8'($urandom), 8'h40 | 8'(e)});
      `CHK(stall_flags[e], 1'b1)
      u.access(1, 1, {8'($urandom), 8'h80 | 8'(e)});
      `CHK(stall_flags[e], 1'b0)
    end
    $display("stall test done");
    v = $urandom;
    u.access(1, 1, 16'h00BA);
    u.access(0, 1, v[15:0]);
    `CHK(hw, v[15:0])
    q.push_back({3'h0, v[15:0]});
    u.access(1, 1, 16'h00BB);
    u.access(0, 0, 16'h0000);
    v = $urandom;
    u.access(1, 1, 16'h00C2);
    u.access(0, 1, v[15:0]);
    u.access(0, 1, v[31:16]);
    `CHK(irq, v)
    q.push_back({3'h0, v[15:0]});
    q.push_back({3'h0, v[31:16]});
    u.access(1, 1, 16'h00C3);
    u.access(0, 0, 16'h0000);
    u.access(0, 0, 16'h0000);
    u.access(1, 1, 16'h0025);
    u.access(0, 1, 16'h005A);
    `CHK(setup[47:40], 8'h5A)
    u.access(1, 1, 16'h00F6);
    `CHK({hw, setup[47:40]}, 24'h00_0000)
    // Empty OUT buffer: count word reads back zero, nothing to discard
    q.push_back(19'h0_0000);
    u.access(1, 1, 16'h0012);
    u.access(0, 0, 16'h0000);
    $display("register test done");
    // Fill the FIFO with the engine stalled, then drain
    q = '{19'h5_0005, 19'h1_1111, 19'h1_2222, 19'h2_3333};
    u.access(1, 1, 16'h0002);
    foreach (q[i]) u.access(0, 1, q[i][15:0]);
    `CHK(bus_wait, 1'b1)
    drain <= 1'b1;
    for (int k = 0; k < 300 && q.size() != 0; k++) @(posedge core_clk);
    if (q.size() != 0) error_cnt++;
    $display("buffer test done");
    conclude();
  end
endmodule : tb
